//--- logic/sio_pkg.sv
package sio_pkg;

    // Configuration select indices
    localparam logic [7:0] IDX_SERIAL_POWER = 8'h02;
    localparam logic [7:0] IDX_PIN_FLOPPY = 8'h03;
    localparam logic [7:0] IDX_PARALLEL_EXT = 8'h04;
    localparam logic [7:0] IDX_RESET = 8'h00;

    // Power-up values
    localparam logic [7:0] SERIAL_POWER_RESET = 8'h88;
    // Printed as a 12-bit figure; the byte kept is its upper eight bits
    localparam logic [11:0] PIN_FLOPPY_PRINTED = 12'h780;
    localparam logic [7:0] PIN_FLOPPY_RESET = PIN_FLOPPY_PRINTED[11:4];
    localparam logic [7:0] PARALLEL_EXT_RESET = 8'h00;

    // Implemented bits; all others read as zero
    localparam logic [7:0] SERIAL_POWER_MASK = 8'h88;
    localparam logic [7:0] PIN_FLOPPY_MASK = 8'hF7;
    localparam logic [7:0] PARALLEL_EXT_MASK = 8'h7F;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Field positions
    localparam int PWR_PRI_BIT = 3;
    localparam int PWR_SEC_BIT = 7;
    localparam int PF_GAME_BIT = 0;
    localparam int PF_ENH_BIT = 1;
    localparam int PF_PIN_LO_BIT = 2;
    localparam int PF_DEN_BIT = 4;
    localparam int PF_IF_LO_BIT = 5;
    localparam int PF_IF_HI_BIT = 6;
    localparam int PF_PIN_HI_BIT = 7;
    localparam int PX_MODE_LO_BIT = 0;
    localparam int PX_MODE_HI_BIT = 1;
    localparam int PX_RAW_LO_BIT = 2;
    localparam int PX_RAW_HI_BIT = 6;

    // Lowest base address that keeps host decoding alive
    localparam int DECODE_MIN_BASE = 256;

    typedef enum logic [1:0] {
        FDC_IF_AT = 2'b11,
        FDC_IF_RESERVED = 2'b10,
        FDC_IF_COMPAT2 = 2'b01,
        FDC_IF_COMPAT3 = 2'b00
    } sio_fdc_if_t;

    typedef enum logic [2:0] {
        PIN_THIRD_DRIVE = 3'b001,
        PIN_ADDR_OUT = 3'b010,
        PIN_IRQ_OUT = 3'b100
    } sio_pin_fn_t;

    typedef enum logic [2:0] {
        PAR_STD_BIDIR = 3'b000,
        PAR_EPP_STD = 3'b001,
        PAR_ECP = 3'b010,
        PAR_ECP_EPP = 3'b011,
        PAR_PRINTER = 3'b100
    } sio_par_mode_t;

    function automatic logic sio_hit(input logic [7:0] sel, input logic [7:0] idx);
        sio_hit = (sel == idx);
    endfunction : sio_hit

endpackage : sio_pkg

//--- logic/sio_cfg_if.sv
`timescale 1ns/100ps
interface sio_cfg_if;
    logic [7:0] sel;
    logic sel_valid;
    logic wr_serial_power;
    logic wr_pin_floppy;
    logic wr_parallel_ext;
    logic [7:0] wdata;

    modport src (
        output sel, sel_valid, wr_serial_power, wr_pin_floppy, wr_parallel_ext, wdata
    );
    modport dst (
        input sel, sel_valid, wr_serial_power, wr_pin_floppy, wr_parallel_ext, wdata
    );
endinterface : sio_cfg_if

//--- logic/sio_index_decode.sv
`timescale 1ns/100ps
module sio_index_decode
    import sio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host port
    input wire logic config_mode,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic [7:0] wdata,
    // Toward the register bank
    sio_cfg_if.src cfg
);

    logic [7:0] config_index_select_reg;
    logic index_valid_reg;

    // Index port only answers in configuration mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            config_index_select_reg <= IDX_RESET;
        end else if (config_mode && index_wr) begin
            config_index_select_reg <= wdata; // [R15]
        end
    end

    // Leaving configuration mode forgets the index, so it must be set again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            index_valid_reg <= 1'b0;
        end else if (!config_mode) begin
            index_valid_reg <= 1'b0;
        end else if (index_wr) begin
            index_valid_reg <= 1'b1; // [R07] [R13]
        end
    end

    logic data_ok;
    assign data_ok = config_mode && index_valid_reg && data_wr && !index_wr; // [R18]

    assign cfg.sel = config_index_select_reg;
    assign cfg.sel_valid = config_mode && index_valid_reg;
    assign cfg.wdata = wdata;
    assign cfg.wr_serial_power = data_ok && sio_hit(config_index_select_reg, IDX_SERIAL_POWER); // [R15]
    assign cfg.wr_pin_floppy = data_ok && sio_hit(config_index_select_reg, IDX_PIN_FLOPPY); // [R07]
    assign cfg.wr_parallel_ext = data_ok && sio_hit(config_index_select_reg, IDX_PARALLEL_EXT); // [R13]

endmodule : sio_index_decode

//--- logic/sio_setup_regs.sv
`timescale 1ns/100ps
// Operation
// R01: Reserved bits read zero, writes ignored
// R02: Index-2 bit 3 powers primary serial port
// R03: Index-2 bit 7 powers secondary serial port
// R04: Power-down keeps address decode registers active
// R05: Decoding off only when base below 100h
// R06: Powered-down valid-base device joins range checks
// R07: Index-3 reached only after selecting 03H
// R08: Index-3 loads its power-up default
// R09: Index-3 bit 1 picks enhanced floppy mode
// R10: Index-3 bit 4 forces density output high
// R11: Index-3 bits 6:5 pick interface mode
// R12: Index-3 bits 7,2 pick shared pin function
// R13: Index-4 reached after selecting 04H, default 00H
// R14: Index-4 bits 1:0 pick parallel mode
// R15: Index port selects register behind data port
// R16: Index-one bit 3 high means printer mode
// R17: Registers load at power-up only
// R18: Unselected or out-of-mode writes change nothing
module sio_setup_regs
    import sio_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock and power-up reset
    input wire logic clk,
    input wire logic rst,
    // Host configuration port
    input wire logic config_mode,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rdata_valid,
    // Serial port bases and controls
    input wire logic [ADDR_W-1:0] primary_base_addr,
    input wire logic [ADDR_W-1:0] secondary_base_addr,
    output logic primary_serial_enable,
    output logic secondary_serial_enable,
    output logic primary_pins_enable,
    output logic secondary_pins_enable,
    output logic primary_decode_enable,
    output logic secondary_decode_enable,
    output logic primary_range_check,
    output logic secondary_range_check,
    // Floppy controls
    input wire logic drive_density_in,
    output logic enhanced_floppy_mode2,
    output sio_fdc_if_t fdc_interface_mode,
    output logic drive_density_out_one,
    output logic game_port_select_mode,
    // Shared pin
    input wire logic address_decode_in,
    input wire logic irq_in,
    input wire logic shared_pin_in,
    output logic shared_pin_out,
    output logic shared_pin_oe,
    output sio_pin_fn_t shared_pin_function,
    output logic third_drive_present,
    // Parallel port
    input wire logic index_one_printer_mode,
    output sio_par_mode_t parallel_port_mode,
    output logic [4:0] parallel_ext_raw
);

    sio_cfg_if cfg ();

    sio_index_decode u_decode (
        .clk(clk),
        .rst(rst),
        .config_mode(config_mode),
        .index_wr(index_wr),
        .data_wr(data_wr),
        .wdata(wdata),
        .cfg(cfg)
    );

    logic [7:0] serial_port_power_control_reg;
    logic [7:0] pin_and_floppy_mode_setup_reg;
    logic [7:0] parallel_serial_extended_setup_reg;
    logic [7:0] rdata_reg;
    logic rdata_valid_reg;

    // Only the power-up reset touches these; a later host reset leaves them alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_port_power_control_reg <= SERIAL_POWER_RESET & SERIAL_POWER_MASK; // [R17]
        end else if (cfg.wr_serial_power) begin
            serial_port_power_control_reg <= cfg.wdata & SERIAL_POWER_MASK; // [R01] [R18]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_and_floppy_mode_setup_reg <= PIN_FLOPPY_RESET & PIN_FLOPPY_MASK; // [R08] [R17]
        end else if (cfg.wr_pin_floppy) begin
            pin_and_floppy_mode_setup_reg <= cfg.wdata & PIN_FLOPPY_MASK; // [R01] [R07]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            parallel_serial_extended_setup_reg <= PARALLEL_EXT_RESET & PARALLEL_EXT_MASK; // [R13] [R17]
        end else if (cfg.wr_parallel_ext) begin
            parallel_serial_extended_setup_reg <= cfg.wdata & PARALLEL_EXT_MASK; // [R13] [R18]
        end
    end

    // Read path: registered, one cycle after the strobe
    logic [7:0] rdata_next;
    always_comb begin
        rdata_next = READ_UNMAPPED;
        if (cfg.sel_valid) begin
            case (cfg.sel)
                IDX_SERIAL_POWER: rdata_next = serial_port_power_control_reg; // [R01]
                IDX_PIN_FLOPPY: rdata_next = pin_and_floppy_mode_setup_reg; // [R07]
                IDX_PARALLEL_EXT: rdata_next = parallel_serial_extended_setup_reg; // [R13]
                default: rdata_next = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (data_rd && config_mode) begin
            rdata_reg <= rdata_next; // [R15]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_valid_reg <= 1'b0;
        end else begin
            rdata_valid_reg <= data_rd && config_mode;
        end
    end

    assign rdata = rdata_reg;
    assign rdata_valid = rdata_valid_reg;

    // Serial power and decode, same logic for both ports
    logic [1:0] power_bit;
    logic [1:0] decode_on;
    logic [1:0] pins_on;
    logic [ADDR_W-1:0] base_addr [0:1];

    assign power_bit[0] = serial_port_power_control_reg[PWR_PRI_BIT]; // [R02]
    assign power_bit[1] = serial_port_power_control_reg[PWR_SEC_BIT]; // [R03]
    assign base_addr[0] = primary_base_addr;
    assign base_addr[1] = secondary_base_addr;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_serial
            // Decode is tied to the base, never to the power bit
            assign decode_on[gi] = (base_addr[gi] >= ADDR_W'(DECODE_MIN_BASE)); // [R04] [R05]
            assign pins_on[gi] = power_bit[gi]; // [R04]
        end
    endgenerate

    assign primary_serial_enable = power_bit[0]; // [R02]
    assign secondary_serial_enable = power_bit[1]; // [R03]
    assign primary_pins_enable = pins_on[0];
    assign secondary_pins_enable = pins_on[1];
    assign primary_decode_enable = decode_on[0];
    assign secondary_decode_enable = decode_on[1];
    // A sleeping port still claims its range in conflict checks
    assign primary_range_check = decode_on[0]; // [R06]
    assign secondary_range_check = decode_on[1]; // [R06]

    // Floppy controls
    assign enhanced_floppy_mode2 = pin_and_floppy_mode_setup_reg[PF_ENH_BIT]; // [R09]
    assign game_port_select_mode = pin_and_floppy_mode_setup_reg[PF_GAME_BIT];

    always_comb begin
        case ({pin_and_floppy_mode_setup_reg[PF_IF_HI_BIT], pin_and_floppy_mode_setup_reg[PF_IF_LO_BIT]})
            2'b11: fdc_interface_mode = FDC_IF_AT; // [R11]
            2'b10: fdc_interface_mode = FDC_IF_RESERVED; // [R11]
            2'b01: fdc_interface_mode = FDC_IF_COMPAT2; // [R11]
            2'b00: fdc_interface_mode = FDC_IF_COMPAT3; // [R11]
            default: fdc_interface_mode = FDC_IF_AT;
        endcase
    end

    assign drive_density_out_one = pin_and_floppy_mode_setup_reg[PF_DEN_BIT] | drive_density_in; // [R10]

    // Shared pin: input unless bit 7 hands it to an output source
    always_comb begin
        case ({pin_and_floppy_mode_setup_reg[PF_PIN_HI_BIT], pin_and_floppy_mode_setup_reg[PF_PIN_LO_BIT]})
            2'b10: shared_pin_function = PIN_ADDR_OUT; // [R12]
            2'b11: shared_pin_function = PIN_IRQ_OUT; // [R12]
            default: shared_pin_function = PIN_THIRD_DRIVE; // [R12]
        endcase
    end

    always_comb begin
        case (shared_pin_function)
            PIN_ADDR_OUT: begin
                shared_pin_out = address_decode_in;
                shared_pin_oe = 1'b1;
            end
            PIN_IRQ_OUT: begin
                shared_pin_out = irq_in;
                shared_pin_oe = 1'b1;
            end
            default: begin
                shared_pin_out = 1'b0;
                shared_pin_oe = 1'b0;
            end
        endcase
    end

    // Sensed pin is masked while it is driven, to avoid reading our own output
    assign third_drive_present = (shared_pin_function == PIN_THIRD_DRIVE) & shared_pin_in; // [R12]

    // Parallel port mode; printer mode overrides the extended bits
    always_comb begin
        if (index_one_printer_mode) begin
            parallel_port_mode = PAR_PRINTER; // [R16]
        end else begin
            case (parallel_serial_extended_setup_reg[PX_MODE_HI_BIT:PX_MODE_LO_BIT])
                2'b00: parallel_port_mode = PAR_STD_BIDIR; // [R14]
                2'b01: parallel_port_mode = PAR_EPP_STD; // [R14]
                2'b10: parallel_port_mode = PAR_ECP; // [R14]
                2'b11: parallel_port_mode = PAR_ECP_EPP; // [R14]
                default: parallel_port_mode = PAR_STD_BIDIR;
            endcase
        end
    end

    assign parallel_ext_raw = parallel_serial_extended_setup_reg[PX_RAW_HI_BIT:PX_RAW_LO_BIT];

endmodule : sio_setup_regs

//--- test/sio_setup_regs_sva.sv
`timescale 1ns/100ps
module sio_setup_regs_sva
    import sio_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock, reset, host
    input wire logic clk,
    input wire logic rst,
    input wire logic config_mode,
    input wire logic data_rd,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    // Serial
    input wire logic [ADDR_W-1:0] primary_base_addr,
    input wire logic primary_serial_enable,
    input wire logic secondary_serial_enable,
    input wire logic primary_pins_enable,
    input wire logic secondary_pins_enable,
    input wire logic primary_decode_enable,
    input wire logic primary_range_check,
    // Floppy, pin, parallel
    input wire logic drive_density_in,
    input wire logic drive_density_out_one,
    input wire logic enhanced_floppy_mode2,
    input wire sio_fdc_if_t fdc_interface_mode,
    input wire logic shared_pin_in,
    input wire logic irq_in,
    input wire logic shared_pin_out,
    input wire logic shared_pin_oe,
    input wire sio_pin_fn_t shared_pin_function,
    input wire logic third_drive_present,
    input wire logic index_one_printer_mode,
    input wire sio_par_mode_t parallel_port_mode,
    input wire logic [4:0] parallel_ext_raw
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD_VALID: assert property (config_mode && data_rd |=> rdata_valid)
        else $error("read not answered");
    AST_NO_VALID: assert property (!(config_mode && data_rd) |=> !rdata_valid ##0 $stable(rdata))
        else $error("read data moved without read");
    AST_PINS_FOLLOW: assert property (primary_pins_enable == primary_serial_enable
        && secondary_pins_enable == secondary_serial_enable)
        else $error("pins enable differs from power");
    AST_DECODE: assert property (primary_decode_enable == (primary_base_addr >= 16'h0100))
        else $error("decode enable wrong");
    AST_RANGE: assert property (primary_range_check == primary_decode_enable)
        else $error("range check wrong");
    AST_DENSITY: assert property (drive_density_in |-> drive_density_out_one)
        else $error("density output not driven");
    AST_PRINTER: assert property (index_one_printer_mode |-> parallel_port_mode == PAR_PRINTER)
        else $error("printer mode not taken");
    AST_HOLD: assert property (!config_mode |=> $stable({primary_serial_enable, secondary_serial_enable,
        enhanced_floppy_mode2, fdc_interface_mode, parallel_ext_raw}))
        else $error("setup changed outside mode");
    AST_THIRD: assert property (shared_pin_function == PIN_THIRD_DRIVE |-> !shared_pin_oe
        && third_drive_present == shared_pin_in)
        else $error("third drive pin wrong");
    AST_IRQ: assert property (shared_pin_function == PIN_IRQ_OUT |-> shared_pin_oe
        && shared_pin_out == irq_in && !third_drive_present)
        else $error("irq pin wrong");
endmodule : sio_setup_regs_sva

//--- test/test_sio_setup_regs.sv
`timescale 1ns/100ps
module test_sio_setup_regs
    import sio_pkg::*;
;
    localparam int ADDR_W = 16;
    logic clk = 0, rst = 1, config_mode = 0, index_wr = 0, data_wr = 0, data_rd = 0;
    logic [7:0] wdata = 8'h00;
    logic [ADDR_W-1:0] primary_base_addr = 16'h03F8, secondary_base_addr = 16'h02F8;
    logic drive_density_in = 0, address_decode_in = 0, irq_in = 0, shared_pin_in = 0, index_one_printer_mode = 1;
    logic [7:0] rdata;
    logic [4:0] parallel_ext_raw;
    logic rdata_valid, primary_serial_enable, secondary_serial_enable, primary_pins_enable, secondary_pins_enable;
    logic primary_decode_enable, secondary_decode_enable, primary_range_check, secondary_range_check;
    logic enhanced_floppy_mode2, drive_density_out_one, game_port_select_mode;
    logic shared_pin_out, shared_pin_oe, third_drive_present;
    sio_fdc_if_t fdc_interface_mode;
    sio_pin_fn_t shared_pin_function;
    sio_par_mode_t parallel_port_mode;
    int failures = 0, n_tests = 0, cycles = 0;

    sio_setup_regs #(.ADDR_W(ADDR_W)) u_sio_setup_regs (.clk, .rst, .config_mode, .index_wr, .data_wr, .data_rd,
        .wdata, .rdata, .rdata_valid, .primary_base_addr, .secondary_base_addr, .primary_serial_enable,
        .secondary_serial_enable, .primary_pins_enable, .secondary_pins_enable, .primary_decode_enable,
        .secondary_decode_enable, .primary_range_check, .secondary_range_check, .drive_density_in,
        .enhanced_floppy_mode2, .fdc_interface_mode, .drive_density_out_one, .game_port_select_mode,
        .address_decode_in, .irq_in, .shared_pin_in, .shared_pin_out, .shared_pin_oe, .shared_pin_function,
        .third_drive_present, .index_one_printer_mode, .parallel_port_mode, .parallel_ext_raw);

    always #20 clk = ~clk;
    // Bench takes about 140 cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            test_done;
        end
    end

    task automatic test_done;
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic strobe(input logic iw, input logic dw, input logic dr, input logic [7:0] v);
        @(negedge clk);
        {index_wr, data_wr, data_rd, wdata} = {iw, dw, dr, v};
        @(negedge clk);
        {index_wr, data_wr, data_rd} = 3'b000;
    endtask : strobe
    task automatic put(input logic [7:0] idx, input logic [7:0] v);
        strobe(1, 0, 0, idx);
        strobe(0, 1, 0, v);
    endtask : put
    task automatic rd_chk(input logic [7:0] exp);
        strobe(0, 0, 1, 8'h00);
        chk1(rdata_valid, 1);
        chk8(rdata, exp);
    endtask : rd_chk
    task automatic get(input logic [7:0] idx, input logic [7:0] exp);
        strobe(1, 0, 0, idx);
        rd_chk(exp);
    endtask : get

    task automatic t_defaults;
        get(IDX_SERIAL_POWER, 8'h88);
        get(IDX_PIN_FLOPPY, 8'h70);
        get(IDX_PARALLEL_EXT, 8'h00);
        chk8(8'(fdc_interface_mode), 8'(FDC_IF_AT));
        chk8(8'(shared_pin_function), 8'(PIN_THIRD_DRIVE));
        chk1(drive_density_out_one, 1);
        chk1(enhanced_floppy_mode2, 0);
        chk1(game_port_select_mode, 0);
    endtask : t_defaults
    task automatic t_refuse;
        // Refused data-only writes carry all ones so that a wrongly taken one shows up later
        config_mode = 0;
        strobe(0, 1, 0, 8'hFF);
        strobe(0, 0, 1, 8'h00);
        chk1(rdata_valid, 0);
        config_mode = 1;
        strobe(0, 1, 0, 8'hFF);
        get(IDX_SERIAL_POWER, 8'h88);
        strobe(1, 1, 0, IDX_SERIAL_POWER);
        rd_chk(8'h88);
        put(8'h05, 8'hFF);
        get(8'h05, 8'h00);
        get(IDX_PIN_FLOPPY, 8'h70);
        get(IDX_PARALLEL_EXT, 8'h00);
    endtask : t_refuse
    task automatic t_reserved;
        put(IDX_SERIAL_POWER, 8'hFF);
        get(IDX_SERIAL_POWER, 8'h88);
        put(IDX_PIN_FLOPPY, 8'hFF);
        get(IDX_PIN_FLOPPY, 8'hF7);
        chk1(game_port_select_mode, 1);
        put(IDX_PARALLEL_EXT, 8'hFF);
        get(IDX_PARALLEL_EXT, 8'h7F);
        chk8({3'h0, parallel_ext_raw}, 8'h1F);
    endtask : t_reserved
    task automatic t_power;
        put(IDX_SERIAL_POWER, 8'h08);
        chk1(primary_serial_enable, 1);
        chk1(secondary_serial_enable, 0);
        put(IDX_SERIAL_POWER, 8'h80);
        chk1(primary_serial_enable, 0);
        chk1(secondary_serial_enable, 1);
        chk1(primary_pins_enable, 0);
        // Powered-down port keeps a valid base; powered port sits below it
        primary_base_addr = 16'h0100;
        secondary_base_addr = 16'h00FF;
        #1 chk1(primary_decode_enable, 1);
        chk1(secondary_decode_enable, 0);
        chk1(secondary_range_check, 0);
        chk1(primary_range_check, 1);
    endtask : t_power
    task automatic t_floppy;
        for (int i = 0; i < 4; i++) begin
            drive_density_in = i[1];
            put(IDX_PIN_FLOPPY, {1'b0, i[1:0], i[0], 2'b00, i[1], 1'b0});
            chk8(8'(fdc_interface_mode), 8'(i[1:0]));
            chk1(drive_density_out_one, i[0] | i[1]);
            chk1(enhanced_floppy_mode2, i[1]);
        end
    endtask : t_floppy
    task automatic t_pin;
        put(IDX_PIN_FLOPPY, 8'h80);
        address_decode_in = 1;
        #1 chk8(8'(shared_pin_function), 8'(PIN_ADDR_OUT));
        chk1(shared_pin_oe, 1);
        chk1(shared_pin_out, 1);
        put(IDX_PIN_FLOPPY, 8'h84);
        // Address source low, so the pin must follow the interrupt source
        irq_in = 1;
        address_decode_in = 0;
        #1 chk8(8'(shared_pin_function), 8'(PIN_IRQ_OUT));
        chk1(shared_pin_out, 1);
        put(IDX_PIN_FLOPPY, 8'h04);
        shared_pin_in = 1;
        #1 chk1(third_drive_present, 1);
    endtask : t_pin
    task automatic t_parallel;
        index_one_printer_mode = 0;
        for (int i = 0; i < 4; i++) begin
            put(IDX_PARALLEL_EXT, {6'h00, i[1:0]});
            chk8(8'(parallel_port_mode), {6'h00, i[1:0]});
        end
        index_one_printer_mode = 1;
        #1 chk8(8'(parallel_port_mode), 8'(PAR_PRINTER));
    endtask : t_parallel

    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        config_mode = 1;
        t_defaults;
        t_refuse;
        t_reserved;
        t_power;
        t_floppy;
        t_pin;
        t_parallel;
        test_done;
    end
endmodule : test_sio_setup_regs

bind sio_setup_regs sio_setup_regs_sva #(.ADDR_W(ADDR_W)) u_sio_setup_regs_sva (.clk, .rst, .config_mode, .data_rd,
    .rdata, .rdata_valid, .primary_base_addr, .primary_serial_enable, .secondary_serial_enable,
    .primary_pins_enable, .secondary_pins_enable, .primary_decode_enable, .primary_range_check,
    .drive_density_in, .drive_density_out_one, .enhanced_floppy_mode2, .fdc_interface_mode, .shared_pin_in,
    .irq_in, .shared_pin_out, .shared_pin_oe, .shared_pin_function, .third_drive_present,
    .index_one_printer_mode, .parallel_port_mode, .parallel_ext_raw);
